// file: dv/tb.sv
// Purpose: self-checking bench for the io and power control register
// Assumes: link model issues one access per call
// Notes:   m mirrors the register, lvl_on marks serial transmit seen
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                   clk = 0, rst = 1, txen = 0, la = 0, lb = 0, lvl_on = 0;
  logic                   rdv, swp, dp, dm, hit;
  logic [7:0]             rdata, m, d;
  int                     err_total = 0, tests_run = 0, i, k, n, op;
  uiopm_pkg::uiopm_mode_t mode = uiopm_pkg::UIOPM_MODE_USB;
  uiopm_pkg::uiopm_req_t  req;
  uiopm_pkg::uiopm_ctl_t  ctl;
  // 50 ns clock
  always #25 clk = ~clk;
  uiopm_link u_uiopm_link (.clk(clk), .req(req));
  uiopm_regs u_uiopm_regs (.clk(clk), .rst(rst), .req(req), .mode(mode),
    .serial_transmit_enable(txen), .phy_line_a(la), .phy_line_b(lb),
    .rdata(rdata), .rdata_valid(rdv), .hit(hit), .data_line_swap(swp),
    .dp_line(dp), .dm_line(dm), .ctl(ctl));
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // address decode seen while each access stands
  always @(negedge clk)
  begin
    #2;
    if (!rst && (req.wr || req.rd))
      chk({7'h00, hit}, {7'h00, req.addr >= 6'h39 && req.addr <= 6'h3B});
  end
  // closing report
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // read with a bounded wait for the data strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    u_uiopm_link.acc(1'b0, a, 8'h00);
    for (n = 0; n < 4 && rdv !== 1'b1; n++)
      @(negedge clk);
    if (n == 4)
    begin
      err_total++;
      stop_test;
    end
    else
      chk(rdata, e);
  endtask
  // routed lines and analog controls against the model
  task automatic pins;
    logic       s;
    logic [1:0] lv;
    logic [1:0] pu;
    la = 1'($urandom);
    lb = 1'($urandom);
    #1;
    s  = m[1] && mode != uiopm_pkg::UIOPM_MODE_AUDIO;
    lv = (mode == uiopm_pkg::UIOPM_MODE_UART && lvl_on) ? m[3:2] : uiopm_pkg::LVL_3V3;
    pu = (mode == uiopm_pkg::UIOPM_MODE_UART) ? 2'h3 : {m[4], m[5]};
    chk({5'h00, swp, dp, dm}, {5'h00, m[1], s ? {lb, la} : {la, lb}});
    chk({3'h0, ctl}, {3'h0, s, lv, pu});
    @(negedge clk);
  endtask
  // main sequence
  initial
  begin
    void'($urandom(34));
    m = 8'h04;
    repeat (20) @(negedge clk);
    rst = 0;
    rd(6'h39, m);
    // random write, set, clear and unmapped writes
    for (i = 0; i < 40; i++)
    begin
      op = $urandom_range(3, 0);
      d = 8'($urandom);
      u_uiopm_link.acc(1'b1, op == 3 ? 6'h3C : 6'h39 + op[5:0], d);
      case (op)
        0: m = d & uiopm_pkg::WRITE_MASK;
        1: m = m | (d & uiopm_pkg::WRITE_MASK);
        2: m = m & ~d;
        default: m = m;
      endcase
      rd(6'h39 + 6'($urandom_range(2, 0)), m);
      pins;
    end
    // every serial level code through audio and serial modes
    for (k = 0; k < 4; k++)
    begin
      d = {2'($urandom), 2'($urandom), k[1:0], 1'($urandom), 1'b0};
      u_uiopm_link.acc(1'b1, 6'h39, d);
      m = d;
      mode = uiopm_pkg::UIOPM_MODE_AUDIO;
      @(negedge clk);
      pins;
      mode = uiopm_pkg::UIOPM_MODE_UART;
      @(negedge clk);
      pins;
      txen = 1;
      lvl_on = 1;
      @(negedge clk);
      pins;
      rst = 1;
      @(negedge clk);
      rst = 0;
      mode = uiopm_pkg::UIOPM_MODE_USB;
      txen = 0;
      lvl_on = 0;
      m = 8'h04;
      rd(6'h3B, m);
    end
    stop_test;
  end
endmodule
`default_nettype wire

// file: dv/uiopm_link.sv
// Purpose: link side model that issues register accesses
// Assumes: requests change at the falling edge of clk
// Notes:   one access per call, strobes dropped one cycle later
`timescale 1ns/100ps
`default_nettype none
module uiopm_link
(
  input  wire logic            clk,
  output uiopm_pkg::uiopm_req_t req
);
  // idle until the bench asks
  initial req = '0;
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req = {w, ~w, a, d};
    @(negedge clk);
    req = '0;
  endtask
endmodule
`default_nettype wire

// file: hw/uiopm_regs.sv
// Purpose: usb io and power management control register with set and clear
// Assumes: link register accesses are synchronous to clk
// Notes:   rst models the active low reset pin already inverted
//
// Behaviour
// - read at three addresses; write, set, clear
// - swap bit exchanges plus and minus pins
// - serial mode routing follows swap bit
// - audio pins ignore swap bit
// - bits 3:2 select serial regulator level
// - level applied when serial transmit asserts
// - audio mode holds regulator at 3.3V
// - bits 4,5 enable data line pullups
// - serial mode forces both pullups on
`timescale 1ns/100ps
`default_nettype none
module uiopm_regs
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire uiopm_pkg::uiopm_req_t   req,
  input  wire uiopm_pkg::uiopm_mode_t  mode,
  input  wire logic                    serial_transmit_enable,
  input  wire logic                    phy_line_a,
  input  wire logic                    phy_line_b,
  output logic [7:0]                   rdata,
  output logic                         rdata_valid,
  output logic                         hit,
  output logic                         data_line_swap,
  output logic                         dp_line,
  output logic                         dm_line,
  output uiopm_pkg::uiopm_ctl_t        ctl
);
  typedef struct packed {
    logic [7:0] reg_v;
    logic [7:0] rdata;
    logic       rvalid;
    logic       serial_active;
    logic [1:0] level;
  } uiopm_state_t;

  uiopm_state_t st_r;
  uiopm_state_t st_nxt;
  logic         is_addr;

  // any of the three addresses is readable
  // address decode
  assign is_addr = (req.addr == uiopm_pkg::ADDR_WRITE) ||
                   (req.addr == uiopm_pkg::ADDR_SET) ||
                   (req.addr == uiopm_pkg::ADDR_CLEAR);
  assign hit = is_addr;

  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (req.wr)
    begin
      case (req.addr)
        uiopm_pkg::ADDR_WRITE: st_nxt.reg_v = req.wdata & uiopm_pkg::WRITE_MASK;
        uiopm_pkg::ADDR_SET:   st_nxt.reg_v = st_r.reg_v | (req.wdata & uiopm_pkg::WRITE_MASK);
        uiopm_pkg::ADDR_CLEAR: st_nxt.reg_v = st_r.reg_v & ~req.wdata;
        default:               st_nxt.reg_v = st_r.reg_v;
      endcase
    end
    else if (req.rd && is_addr)
    begin
      st_nxt.rdata  = st_r.reg_v & uiopm_pkg::WRITE_MASK;
      st_nxt.rvalid = 1'b1;
    end
    // latch serial level on transmit enable
    if (mode == uiopm_pkg::UIOPM_MODE_UART && serial_transmit_enable)
    begin
      st_nxt.serial_active = 1'b1;
      st_nxt.level = st_r.reg_v[uiopm_pkg::BIT_LVL_LO +: 2];
    end
    else if (mode == uiopm_pkg::UIOPM_MODE_UART && st_r.serial_active)
    begin
      // later field writes still reach the regulator once serial is up
      st_nxt.level = st_r.reg_v[uiopm_pkg::BIT_LVL_LO +: 2];
    end
    else if (mode != uiopm_pkg::UIOPM_MODE_UART)
    begin
      st_nxt.serial_active = 1'b0;
      st_nxt.level = uiopm_pkg::LVL_3V3;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r.reg_v         <= uiopm_pkg::RESET_VALUE;
      st_r.rdata         <= 8'h00;
      st_r.rvalid        <= 1'b0;
      st_r.serial_active <= 1'b0;
      st_r.level         <= uiopm_pkg::LVL_3V3;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata          = st_r.rdata;
  assign rdata_valid    = st_r.rvalid;
  assign data_line_swap = st_r.reg_v[uiopm_pkg::BIT_SWAP];

  uiopm_route u_route
  (
    .swap       (data_line_swap),
    .mode       (mode),
    .line_a     (phy_line_a),
    .line_b     (phy_line_b),
    .plus_line  (dp_line),
    .minus_line (dm_line)
  );

  // analog control outputs
  always_comb
  begin
    ctl.plus_to_phy_minus = data_line_swap && (mode != uiopm_pkg::UIOPM_MODE_AUDIO);
    if (mode == uiopm_pkg::UIOPM_MODE_AUDIO)
      ctl.regulator_level = uiopm_pkg::LVL_3V3;
    else
      ctl.regulator_level = st_r.level;
    ctl.plus_pullup_on  = st_r.reg_v[uiopm_pkg::BIT_PLUS_PU] ||
                          (mode == uiopm_pkg::UIOPM_MODE_UART);
    ctl.minus_pullup_on = st_r.reg_v[uiopm_pkg::BIT_MINUS_PU] ||
                          (mode == uiopm_pkg::UIOPM_MODE_UART);
  end

  property p_set_bits;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == uiopm_pkg::ADDR_SET) |=>
        ((st_r.reg_v & ($past(req.wdata) & uiopm_pkg::WRITE_MASK)) ==
         ($past(req.wdata) & uiopm_pkg::WRITE_MASK));
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("set lost a bit");

  property p_clr_bits;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == uiopm_pkg::ADDR_CLEAR) |=>
        ((st_r.reg_v & $past(req.wdata)) == 8'h00);
  endproperty
  a_clr_bits: assert property (p_clr_bits) else $error("clear left a bit");

  property p_read;
    @(posedge clk) disable iff (rst)
      (req.rd && !req.wr && is_addr) |=> (rdata_valid && rdata == $past(st_r.reg_v));
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_zero;
    @(posedge clk) disable iff (rst) rdata_valid |-> !rdata[uiopm_pkg::BIT_ZERO];
  endproperty
  a_zero: assert property (p_zero) else $error("bit 0 read as one");

  property p_swap;
    @(posedge clk) disable iff (rst)
      (data_line_swap && mode == uiopm_pkg::UIOPM_MODE_USB) |-> (dp_line == phy_line_b);
  endproperty
  a_swap: assert property (p_swap) else $error("swap not applied");

  property p_uart_swap;
    @(posedge clk) disable iff (rst)
      (data_line_swap && mode == uiopm_pkg::UIOPM_MODE_UART) |-> (dm_line == phy_line_a);
  endproperty
  a_uart_swap: assert property (p_uart_swap) else $error("serial swap missing");

  property p_audio;
    @(posedge clk) disable iff (rst)
      (mode == uiopm_pkg::UIOPM_MODE_AUDIO) |->
        (dp_line == phy_line_a && ctl.regulator_level == uiopm_pkg::LVL_3V3);
  endproperty
  a_audio: assert property (p_audio) else $error("audio mode wrong");

  property p_level;
    @(posedge clk) disable iff (rst)
      (mode == uiopm_pkg::UIOPM_MODE_UART && serial_transmit_enable) |=>
        (mode != uiopm_pkg::UIOPM_MODE_UART ||
         ctl.regulator_level == $past(st_r.reg_v[uiopm_pkg::BIT_LVL_LO +: 2]));
  endproperty
  a_level: assert property (p_level) else $error("serial level not applied");

  property p_pullup;
    @(posedge clk) disable iff (rst)
      (mode == uiopm_pkg::UIOPM_MODE_UART) |-> (ctl.plus_pullup_on && ctl.minus_pullup_on);
  endproperty
  a_pullup: assert property (p_pullup) else $error("serial pullups off");

  property p_pullup_bits;
    @(posedge clk) disable iff (rst)
      (mode != uiopm_pkg::UIOPM_MODE_UART) |->
        (ctl.plus_pullup_on == st_r.reg_v[uiopm_pkg::BIT_PLUS_PU] &&
         ctl.minus_pullup_on == st_r.reg_v[uiopm_pkg::BIT_MINUS_PU]);
  endproperty
  a_pullup_bits: assert property (p_pullup_bits) else $error("pullup bit not applied");
endmodule
`default_nettype wire

// file: hw/uiopm_route.sv
// Purpose: data line routing for usb, serial and audio modes
// Assumes: swap select comes from the control register
// Notes:   audio outputs are never swapped
`timescale 1ns/100ps
`default_nettype none
module uiopm_route
(
  input  wire logic               swap,
  input  wire uiopm_pkg::uiopm_mode_t mode,
  input  wire logic               line_a,
  input  wire logic               line_b,
  output logic                    plus_line,
  output logic                    minus_line
);
  // swap applies in usb and serial mode, never in audio
  // serial follows swap
  always_comb
  begin
    if (swap && (mode != uiopm_pkg::UIOPM_MODE_AUDIO))
    begin
      plus_line  = line_b;
      minus_line = line_a;
    end
    else
    begin
      plus_line  = line_a;
      minus_line = line_b;
    end
  end
endmodule
`default_nettype wire

// file: pkg/uiopm_pkg.sv
// Purpose: shared constants and carriers for the io and power control register
// Assumes: eight-bit register reached by the link's register access port
// Notes:   encodings and offsets are used by name in the design
`default_nettype none
package uiopm_pkg;
  // register addresses
  localparam logic [5:0] ADDR_WRITE = 6'h39;
  localparam logic [5:0] ADDR_SET   = 6'h3A;
  localparam logic [5:0] ADDR_CLEAR = 6'h3B;
  // field positions
  localparam int BIT_ZERO       = 0;
  localparam int BIT_SWAP       = 1;
  localparam int BIT_LVL_LO     = 2;
  localparam int BIT_PLUS_PU    = 4;
  localparam int BIT_MINUS_PU   = 5;
  localparam int BIT_USB_LVL_LO = 6;
  // reset value: serial level 01, rest zero
  localparam logic [7:0] RESET_VALUE = 8'h04;
  // writable bits (bit 0 reads zero)
  localparam logic [7:0] WRITE_MASK  = 8'hFE;
  // regulator level codes
  localparam logic [1:0] LVL_3V3  = 2'h0;
  localparam logic [1:0] LVL_3V0  = 2'h1;
  localparam logic [1:0] LVL_2V75 = 2'h2;
  localparam logic [1:0] LVL_2V5  = 2'h3;

  typedef enum logic [1:0] {
    UIOPM_MODE_USB   = 2'h0,
    UIOPM_MODE_UART  = 2'h1,
    UIOPM_MODE_AUDIO = 2'h2
  } uiopm_mode_t;

  // register access from the link
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } uiopm_req_t;

  // pin routing and analog controls
  typedef struct packed {
    logic       plus_to_phy_minus;
    logic [1:0] regulator_level;
    logic       plus_pullup_on;
    logic       minus_pullup_on;
  } uiopm_ctl_t;
endpackage
`default_nettype wire
